/* File: verilog/plc_basic_logic_blocks.sv */
// Function
// - edge nand fires when all-high turns low
// - edge pulse one cycle, then low
// - unused edge nand inputs read one
// - nor is one only if all zero
// - unused nor inputs read zero
// - not block complements its input
// - four-input table, input one is lsb
// - unconnected table inputs select as zero
// - table writable once input connected, reachable only
// - polarity chooses table value or inverse
// - set drives special-function output high
// - reset clears output, overrides every input
// - enable low ignores set and invert; reset and reset-all still act
// - invert complements the normal output
// - reset-all clears every internal value
// - time base selects units of timer parameter
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
module plc_basic_logic_blocks (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // program cycle tick and block inputs
    input wire logic tick_i,
    input wire plc_blocks_pkg::logic_in_t blk_i,
    input wire plc_blocks_pkg::sf_ctrl_t sf_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // block outputs
    output plc_blocks_pkg::logic_out_t out_o
);

    ////////////////////////////////////////////////////////////////////////
    // functions

    // table entries whose index needs only connected inputs
    function automatic logic [15:0] reachable_mask(input logic [3:0] used);
        logic [15:0] m;
        m = 16'h0000;
        for (int i = 0; i < 16; i++)
        begin
            m[i] = ((4'(i) & ~used) == 4'h0);
        end
        return m;
    endfunction : reachable_mask

    // timer parameter to hundredths of a second
    function automatic logic [31:0] time_to_centi(input logic [17:0] t);
        logic [31:0] hi;
        logic [31:0] lo;
        logic [31:0] r;
        hi = {24'h000000, t[plc_blocks_pkg::TIME_HI_LSB +: 8]};
        lo = {24'h000000, t[plc_blocks_pkg::TIME_LO_LSB +: 8]};
        case (t[plc_blocks_pkg::TIME_BASE_LSB +: 2])
            plc_blocks_pkg::TB_SECONDS:
                r = 32'(hi * plc_blocks_pkg::CENTI_PER_SEC + lo);
            plc_blocks_pkg::TB_MINUTES:
                r = 32'((hi * plc_blocks_pkg::SEC_PER_MIN + lo) * plc_blocks_pkg::CENTI_PER_SEC);
            plc_blocks_pkg::TB_HOURS:
                r = 32'((hi * plc_blocks_pkg::MIN_PER_HOUR + lo) * plc_blocks_pkg::SEC_PER_MIN
                    * plc_blocks_pkg::CENTI_PER_SEC);
            default:
                r = 32'h00000000;
        endcase
        return r;
    endfunction : time_to_centi

    ////////////////////////////////////////////////////////////////////////
    // reset release

    logic rst_meta_q;
    logic rst_n_q;

    // release through two flops, assert at once
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [3:0] nand_used;
        logic [3:0] nor_used;
        logic [3:0] tt_used;
        logic polarity;
        logic [15:0] tt_map;
        logic [17:0] time_par;
        logic [3:0] nand_prev;
        logic nand_out;
        logic nor_out;
        logic not_out;
        logic tt_out;
        plc_blocks_pkg::sf_state_t sf_state;
        logic sf_inv;
        logic sf_out;
        logic [15:0] sf_elapsed;
        logic [31:0] rdata;
    } state_t;

    localparam state_t STATE_RST = '{
        nand_used: plc_blocks_pkg::NAND_USED_RST,
        nor_used: plc_blocks_pkg::NOR_USED_RST,
        tt_used: plc_blocks_pkg::TT_USED_RST,
        polarity: 1'b0,
        tt_map: plc_blocks_pkg::TT_MAP_RST,
        time_par: plc_blocks_pkg::TIME_RST,
        nand_prev: plc_blocks_pkg::NAND_PREV_RST,
        nand_out: 1'b0,
        nor_out: 1'b0,
        not_out: 1'b0,
        tt_out: 1'b0,
        sf_state: plc_blocks_pkg::SF_OFF,
        sf_inv: 1'b0,
        sf_out: 1'b0,
        sf_elapsed: 16'h0000,
        rdata: 32'h00000000
    };

    state_t s_q;
    state_t s_d;
    logic [3:0] nand_eff;
    logic [3:0] tt_idx;
    logic [15:0] tt_mask;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_d = s_q;
        s_d.rdata = 32'h00000000;
        nand_eff = blk_i.nand_in | ~s_q.nand_used;
        tt_idx = blk_i.tt_in & s_q.tt_used;
        tt_mask = reachable_mask(s_q.tt_used);

        // register writes
        if (wr_i)
        begin
            case (addr_i)
                plc_blocks_pkg::REG_CTRL:
                begin
                    s_d.nand_used = wdata_i[plc_blocks_pkg::CTRL_NAND_USED_LSB +: 4];
                    s_d.nor_used = wdata_i[plc_blocks_pkg::CTRL_NOR_USED_LSB +: 4];
                    s_d.tt_used = wdata_i[plc_blocks_pkg::CTRL_TT_USED_LSB +: 4];
                    s_d.polarity = wdata_i[plc_blocks_pkg::CTRL_POLARITY_BIT];
                end
                plc_blocks_pkg::REG_TT_MAP:
                begin
                    if (|s_q.tt_used)
                    begin
                        s_d.tt_map = (s_q.tt_map & ~tt_mask) | (wdata_i[15:0] & tt_mask);
                    end
                end
                plc_blocks_pkg::REG_TIME:
                begin
                    s_d.time_par = wdata_i[17:0];
                end
                default:
                begin
                    s_d.time_par = s_q.time_par;
                end
            endcase
        end

        // register reads, unmapped words read zero
        if (rd_i)
        begin
            case (addr_i)
                plc_blocks_pkg::REG_CTRL:
                begin
                    s_d.rdata[plc_blocks_pkg::CTRL_NAND_USED_LSB +: 4] = s_q.nand_used;
                    s_d.rdata[plc_blocks_pkg::CTRL_NOR_USED_LSB +: 4] = s_q.nor_used;
                    s_d.rdata[plc_blocks_pkg::CTRL_TT_USED_LSB +: 4] = s_q.tt_used;
                    s_d.rdata[plc_blocks_pkg::CTRL_POLARITY_BIT] = s_q.polarity;
                end
                plc_blocks_pkg::REG_TT_MAP:
                begin
                    s_d.rdata[15:0] = s_q.tt_map;
                end
                plc_blocks_pkg::REG_TIME:
                begin
                    s_d.rdata[17:0] = s_q.time_par;
                end
                plc_blocks_pkg::REG_TIME_CENTI:
                begin
                    s_d.rdata = time_to_centi(s_q.time_par);
                end
                plc_blocks_pkg::REG_STATUS:
                begin
                    s_d.rdata[plc_blocks_pkg::STAT_NAND_BIT] = s_q.nand_out;
                    s_d.rdata[plc_blocks_pkg::STAT_NOR_BIT] = s_q.nor_out;
                    s_d.rdata[plc_blocks_pkg::STAT_NOT_BIT] = s_q.not_out;
                    s_d.rdata[plc_blocks_pkg::STAT_TT_BIT] = s_q.tt_out;
                    s_d.rdata[plc_blocks_pkg::STAT_SF_BIT] = s_q.sf_out;
                    s_d.rdata[plc_blocks_pkg::STAT_SF_ON_BIT] =
                        (s_q.sf_state == plc_blocks_pkg::SF_ON);
                    s_d.rdata[plc_blocks_pkg::STAT_ELAPSED_LSB +: 16] = s_q.sf_elapsed;
                end
                default:
                begin
                    s_d.rdata = 32'h00000000;
                end
            endcase
        end

        if (tick_i)
        begin
            s_d.nand_prev = nand_eff;
            s_d.nand_out = (&s_q.nand_prev) & ~(&nand_eff) & ~s_q.nand_out;
            s_d.nor_out = ~|(blk_i.nor_in & s_q.nor_used);
            s_d.not_out = ~blk_i.not_in;
            s_d.tt_out = s_q.tt_map[tt_idx] ^ s_q.polarity;

            // reset and reset-all act even with enable low
            if (sf_i.ral)
            begin
                s_d.sf_state = plc_blocks_pkg::SF_OFF;
                s_d.sf_elapsed = 16'h0000;
                s_d.sf_inv = 1'b0;
            end
            else if (sf_i.rst)
            begin
                s_d.sf_state = plc_blocks_pkg::SF_OFF;
            end
            else if (sf_i.en)
            begin
                s_d.sf_inv = sf_i.inv;
                case (s_q.sf_state)
                    plc_blocks_pkg::SF_OFF:
                    begin
                        if (sf_i.set)
                        begin
                            s_d.sf_state = plc_blocks_pkg::SF_ON;
                        end
                    end
                    plc_blocks_pkg::SF_ON:
                    begin
                        // saturates rather than wrap back to zero
                        if (~&s_q.sf_elapsed)
                        begin
                            s_d.sf_elapsed = 16'(s_q.sf_elapsed + 16'h0001);
                        end
                    end
                    default:
                    begin
                        s_d.sf_state = plc_blocks_pkg::SF_OFF;
                    end
                endcase
            end
            if (sf_i.rst || sf_i.ral)
            begin
                s_d.sf_out = 1'b0;
            end
            else
            begin
                s_d.sf_out = (s_d.sf_state == plc_blocks_pkg::SF_ON) ^ s_d.sf_inv;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            s_q <= STATE_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign out_o.nand_out = s_q.nand_out;
    assign out_o.nor_out = s_q.nor_out;
    assign out_o.not_out = s_q.not_out;
    assign out_o.tt_out = s_q.tt_out;
    assign out_o.sf_out = s_q.sf_out;

endmodule : plc_basic_logic_blocks

/* File: verilog/plc_blocks_pkg.sv */
package plc_blocks_pkg;

    // register map, word index on a 4-bit address port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TT_MAP = 4'h1;
    localparam logic [3:0] REG_TIME = 4'h2;
    localparam logic [3:0] REG_TIME_CENTI = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;

    // control register fields
    localparam int CTRL_NAND_USED_LSB = 0;
    localparam int CTRL_NOR_USED_LSB = 4;
    localparam int CTRL_TT_USED_LSB = 8;
    localparam int CTRL_POLARITY_BIT = 12;

    // time register fields
    localparam int TIME_LO_LSB = 0;
    localparam int TIME_HI_LSB = 8;
    localparam int TIME_BASE_LSB = 16;

    // status register fields
    localparam int STAT_NAND_BIT = 0;
    localparam int STAT_NOR_BIT = 1;
    localparam int STAT_NOT_BIT = 2;
    localparam int STAT_TT_BIT = 3;
    localparam int STAT_SF_BIT = 4;
    localparam int STAT_SF_ON_BIT = 5;
    localparam int STAT_ELAPSED_LSB = 16;

    // reset values
    localparam logic [3:0] NAND_USED_RST = 4'hf;
    localparam logic [3:0] NOR_USED_RST = 4'hf;
    localparam logic [3:0] TT_USED_RST = 4'h0;
    localparam logic [15:0] TT_MAP_RST = 16'h0000;
    localparam logic [17:0] TIME_RST = 18'h00000;
    localparam logic [3:0] NAND_PREV_RST = 4'h0;

    // time bases and unit ratios
    localparam logic [1:0] TB_SECONDS = 2'h0;
    localparam logic [1:0] TB_MINUTES = 2'h1;
    localparam logic [1:0] TB_HOURS = 2'h2;
    localparam logic [31:0] CENTI_PER_SEC = 32'h00000064;
    localparam logic [31:0] SEC_PER_MIN = 32'h0000003c;
    localparam logic [31:0] MIN_PER_HOUR = 32'h0000003c;

    typedef enum logic {SF_OFF, SF_ON} sf_state_t;

    // per program cycle input levels
    typedef struct packed {
        logic [3:0] nand_in;
        logic [3:0] nor_in;
        logic not_in;
        logic [3:0] tt_in;
    } logic_in_t;

    // special-function control inputs
    typedef struct packed {
        logic set;
        logic rst;
        logic en;
        logic inv;
        logic ral;
    } sf_ctrl_t;

    typedef struct packed {
        logic nand_out;
        logic nor_out;
        logic not_out;
        logic tt_out;
        logic sf_out;
    } logic_out_t;

endpackage : plc_blocks_pkg

/* File: tb/plc_blocks_monitor.sv */
`timescale 1ns/1ns
module plc_blocks_monitor (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // block side
    input wire logic tick_i,
    input wire plc_blocks_pkg::logic_in_t blk_i,
    input wire plc_blocks_pkg::sf_ctrl_t sf_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire plc_blocks_pkg::logic_out_t out_o
);
    logic [12:0] ctrl_q;
    logic [15:0] map_q;
    logic [3:0] prev_q;
    logic [3:0] nd_w;
    assign nd_w = blk_i.nand_in | ~ctrl_q[3:0];
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of config, writes land one cycle late like the block's own
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl_q <= 13'h00ff;
            map_q <= 16'h0000;
            prev_q <= 4'h0;
        end
        else
        begin
            if (wr_i && addr_i == plc_blocks_pkg::REG_CTRL)
                ctrl_q <= wdata_i[12:0];
            if (wr_i && addr_i == plc_blocks_pkg::REG_TT_MAP && ctrl_q[11:8] != 4'h0)
                for (int i = 0; i < 16; i++)
                    if ((4'(i) & ~ctrl_q[11:8]) == 4'h0)
                        map_q[i] <= wdata_i[i];
            if (tick_i)
                prev_q <= nd_w;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    hold_no_tick_a: assert property (!tick_i |=> $stable(out_o))
        else $error("outputs moved without tick");
    nand_edge_a: assert property (tick_i |=> out_o.nand_out ==
        ((&$past(prev_q)) && !(&$past(nd_w)))) else $error("edge nand wrong");
    nand_once_a: assert property (tick_i && out_o.nand_out |=> !out_o.nand_out)
        else $error("edge nand pulse too long");
    nor_value_a: assert property (tick_i |=> out_o.nor_out ==
        !(|$past(blk_i.nor_in & ctrl_q[7:4]))) else $error("nor wrong");
    not_value_a: assert property (tick_i |=> out_o.not_out == !$past(blk_i.not_in))
        else $error("not wrong");
    table_out_a: assert property (tick_i |=> out_o.tt_out ==
        ($past(map_q[blk_i.tt_in & ctrl_q[11:8]]) ^ $past(ctrl_q[12]))) else $error("table wrong");
    sf_reset_a: assert property (tick_i && sf_i.rst |=> !out_o.sf_out)
        else $error("reset did not clear");
    sf_ral_a: assert property (tick_i && sf_i.ral |=> !out_o.sf_out)
        else $error("reset all did not clear");
    sf_set_a: assert property (tick_i && sf_i.en && sf_i.set && !sf_i.rst
        && !sf_i.ral && !sf_i.inv |=> out_o.sf_out) else $error("set did not drive one");
    rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data outside read slot");
    cover property (tick_i ##1 out_o.nand_out);
    cover property (tick_i ##1 out_o.tt_out);
    cover property (tick_i ##1 out_o.sf_out);
endmodule : plc_blocks_monitor

bind plc_basic_logic_blocks plc_blocks_monitor mon (.clk_i(clk_i), .nrst_i(nrst_i),
    .tick_i(tick_i), .blk_i(blk_i), .sf_i(sf_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .out_o(out_o));

/* File: tb/test_plc_basic_logic_blocks.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch at %0t got %h want %h", $time, a, b); end end
module test_plc_basic_logic_blocks;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic tick = 1'b0;
    plc_blocks_pkg::logic_in_t blk = '0;
    plc_blocks_pkg::sf_ctrl_t sf = '0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    plc_blocks_pkg::logic_out_t out;
    int n_tests = 0;
    int miscompares = 0;
    int cyc = 0;
    logic rd_d = 1'b0;
    logic tk_d = 1'b0;
    logic [31:0] rq[$];
    plc_blocks_pkg::logic_out_t oq[$];
    logic [31:0] er;
    plc_blocks_pkg::logic_out_t eo;
    logic [12:0] c_q = 13'h00ff;
    logic [15:0] map = 16'h0;
    logic [3:0] nprev = 4'h0;
    logic on = 1'b0;
    logic invl = 1'b0;
    logic [31:0] lf = 32'd75496;
    logic [31:0] v;
    localparam logic [3:0] NSEQ [7] = '{4'hf, 4'he, 4'hf, 4'hf, 4'h0, 4'hf, 4'h7};
    localparam logic [4:0] SFSEQ [9] = '{5'h14, 5'h04, 5'h02, 5'h06, 5'h1e, 5'h06, 5'h01,
        5'h10, 5'h04};
    plc_basic_logic_blocks DUT (.clk_i(clk), .nrst_i(nrst), .tick_i(tick), .blk_i(blk),
        .sf_i(sf), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .out_o(out));
    initial
    begin
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        if (a == plc_blocks_pkg::REG_CTRL)
            c_q = d[12:0];
        if (a == plc_blocks_pkg::REG_TT_MAP && c_q[11:8] != 4'h0)
            for (int i = 0; i < 16; i++)
                if ((4'(i) & ~c_q[11:8]) == 4'h0)
                    map[i] = d[i];
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg
    task automatic tk(input plc_blocks_pkg::logic_in_t b, input plc_blocks_pkg::sf_ctrl_t s);
        plc_blocks_pkg::logic_out_t e;
        logic [3:0] nd;
        nd = b.nand_in | ~c_q[3:0];
        e.nand_out = (&nprev) & ~(&nd);
        e.nor_out = ~|(b.nor_in & c_q[7:4]);
        e.not_out = ~b.not_in;
        e.tt_out = map[b.tt_in & c_q[11:8]] ^ c_q[12];
        // gating holds set and invert back
        if (s.rst || s.ral)
            on = 1'b0;
        else if (s.en && s.set)
            on = 1'b1;
        if (s.ral)
            invl = 1'b0;
        else if (s.en)
            invl = s.inv;
        e.sf_out = (s.rst || s.ral) ? 1'b0 : on ^ invl;
        nprev = nd;
        oq.push_back(e);
        @(posedge clk);
        blk <= b;
        sf <= s;
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
    endtask : tk
    ////////////////////////////////////////////////////////////////////////////////
    // result watcher; the ceiling is several times the expected run
    always @(posedge clk)
    begin
        rd_d <= rd;
        tk_d <= tick;
        cyc++;
        if (rd_d)
        begin
            er = rq.pop_front();
            `CHK(rdata, er)
        end
        if (tk_d)
        begin
            eo = oq.pop_front();
            `CHK(out, eo)
        end
        if (cyc > 6000)
        begin
            miscompares++;
            close_out();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        for (int r = 0; r < 2; r++)
        begin
            // reset values, unmapped and read-only writes ignored
            rd_reg(plc_blocks_pkg::REG_CTRL, 32'h000000ff);
            rd_reg(plc_blocks_pkg::REG_TT_MAP, 32'h0);
            wr_reg(4'hf, 32'hffffffff);
            wr_reg(plc_blocks_pkg::REG_STATUS, 32'hffffffff);
            rd_reg(4'h5, 32'h0);
            rd_reg(plc_blocks_pkg::REG_CTRL, 32'h000000ff);
            foreach (NSEQ[i])
                tk({NSEQ[i], 9'h0}, '0);
            $display("reset and edge test done");
            for (int k = 0; k < 4; k++)
            begin
                lf = lfsr(lf);
                wr_reg(plc_blocks_pkg::REG_CTRL, {24'h0, lf[23:16]});
                repeat (20)
                begin
                    lf = lfsr(lf);
                    tk(lf[12:0], '0);
                end
            end
            $display("gate test done");
            // table writes refused until an input is connected
            wr_reg(plc_blocks_pkg::REG_TT_MAP, 32'hffff);
            rd_reg(plc_blocks_pkg::REG_TT_MAP, 32'h0);
            wr_reg(plc_blocks_pkg::REG_CTRL, 32'h03ff);
            wr_reg(plc_blocks_pkg::REG_TT_MAP, 32'hffff);
            rd_reg(plc_blocks_pkg::REG_TT_MAP, 32'h000f);
            lf = lfsr(lf);
            wr_reg(plc_blocks_pkg::REG_CTRL, 32'h0fff);
            wr_reg(plc_blocks_pkg::REG_TT_MAP, {16'h0, lf[15:0]});
            for (int p = 0; p < 2; p++)
            begin
                wr_reg(plc_blocks_pkg::REG_CTRL, {19'h0, 1'(p), 12'hfff});
                for (int i = 0; i < 16; i++)
                    tk({9'h0, 4'(i)}, '0);
            end
            wr_reg(plc_blocks_pkg::REG_CTRL, 32'h05ff);
            repeat (16)
            begin
                lf = lfsr(lf);
                tk(lf[12:0], '0);
            end
            $display("table test done");
            for (int b = 0; b < 4; b++)
            begin
                lf = lfsr(lf);
                v = {14'h0, 2'(b), lf[15:0]};
                wr_reg(plc_blocks_pkg::REG_TIME, v);
                rd_reg(plc_blocks_pkg::REG_TIME, v);
                case (b)
                    0: v = lf[15:8] * 100 + lf[7:0];
                    1: v = (lf[15:8] * 60 + lf[7:0]) * 100;
                    2: v = (lf[15:8] * 60 + lf[7:0]) * 6000;
                    default: v = 32'h0;
                endcase
                rd_reg(plc_blocks_pkg::REG_TIME_CENTI, v);
            end
            $display("time test done");
            foreach (SFSEQ[i])
            begin
                lf = lfsr(lf);
                tk(lf[12:0], SFSEQ[i]);
            end
            $display("special function test done");
            // second reset in mid-run, model back to its start
            repeat (3) @(posedge clk);
            nrst <= 1'b0;
            repeat (2) @(posedge clk);
            nrst <= 1'b1;
            c_q = 13'h00ff;
            map = 16'h0;
            nprev = 4'h0;
            on = 1'b0;
            invl = 1'b0;
            repeat (3) @(posedge clk);
        end
        close_out();
    end
endmodule : test_plc_basic_logic_blocks
